// file: rcs_sequencer.sv
// Operating sequencer of a half-bridge resonant converter controller.
// Assumes all comparator flags are already synchronous to clk.
// Overview of operation
// - First turn-on enables bulk monitor, feedback, fault sense and Output_a blocks.
// - Each supply turn-on starts blanking that ignores all fault inputs.
// - Drivers start only after blanking ends with no fault present.
// - Persisting fault after blanking keeps blocks biased under self-supply.
// - Bulk good while waiting leaves self-supply so startup source recharges supply.
// - Bulk loss while running stops drivers and unbiases fault sense block.
// - Output_a output stays high during brown-out wait.
// - Brown-out wait sustains supply with startup source in self-supply mode.
// - Turn-on after brown-out biases fault sense and blanks together, then restarts.
// - Overvoltage/overtemperature input high while running latches off all but feedback and supply management.
// - Latch holds under self-supply until supply drops below release level.
// - Feedback below skip entry at first turn-on withholds start-up.
// - Overload stops switching, keeps feedback and fault logic, self-supplies.
// - Overload starts recovery timer; expiry leaves self-supply so startup source recharges.
// - Recovery turn-on starts supply and fault blanking, then soft-start.
// - Overvoltage after blanking keeps drivers off; clearing starts fresh attempt.
// - Skip threshold switches off all but feedback, including supply management.
// - Skip exit re-enables blocks and drivers without startup source.
// - Each skip burst starts an overtemperature blanking period.
// - Brown-out in skip is ignored; it is acted on once skip exit returns to running.
// - Brown-out wait from skip drives Output_a output at PFC-on level.
// - Supply below turn-off level in skip enters off-mode.
`timescale 1ns/1ps
module rcs_sequencer
	import rcs_pkg::*;
#(
	parameter int unsigned RECOVERY_CYC = RECOVERY_DELAY_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic supply_above_turn_on,
	input wire logic supply_above_turn_off,
	input wire logic supply_above_release,
	input wire logic bulk_level_good,
	input wire logic fb_below_skip_entry,
	input wire logic fb_above_skip_exit,
	input wire logic overvoltage_overtemp_input,
	input wire logic overload_detect,
	output logic bulk_monitor_en,
	output logic feedback_en,
	output logic fault_sense_en,
	output logic fault_logic_en,
	output logic gate_drivers_en,
	output logic startup_source_en,
	output logic self_supply_mode,
	output logic output_a,
	output logic soft_start,
	output logic ot_blank_active,
	output logic [3:0] seq_state
);

	rcs_state_e state_q;
	rcs_state_e state_d;
	logic on_q;
	logic on_rise;
	logic first_on_q;
	logic blk_start;
	logic blk_busy;
	logic blk_done;
	logic rec_start;
	logic rec_done;
	logic otb_start;
	logic otb_busy;
	logic ot_fault;

	// Turn-on is an event, so only the rising crossing counts
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			on_q <= 1'b0;
		end else begin
			on_q <= supply_above_turn_on;
		end
	end

	assign on_rise = supply_above_turn_on & ~on_q;

	// Set from a supply reset until the converter first runs, so a start
	// withheld for light load stays in brown-out wait until feedback rises
	always_ff @(posedge clk) begin
		if (sys_rst || !supply_above_release) begin
			first_on_q <= 1'b1;
		end else if (state_q == RCS_RUNNING) begin
			first_on_q <= 1'b0;
		end
	end

	assign blk_start = (state_q == RCS_CHARGING) && on_rise;
	assign rec_start = (state_d == RCS_RECOVERY_WAIT) && (state_q != RCS_RECOVERY_WAIT);
	assign otb_start = (state_q == RCS_SKIP_IDLE) && fb_above_skip_exit;

	rcs_timer #(.W(CNT_W)) u_blank (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(blk_start),
		.load(CNT_W'(SUPPLY_BLANK_CYC)),
		.busy(blk_busy),
		.done(blk_done)
	);

	rcs_timer #(.W(CNT_W)) u_recovery (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(rec_start),
		.load(CNT_W'(RECOVERY_CYC)),
		.busy(),
		.done(rec_done)
	);

	// Fault blanking after turn-on and at each burst masks the fault input
	rcs_timer #(.W(CNT_W)) u_ot_blank (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(otb_start | blk_start),
		.load(CNT_W'(OT_BLANK_CYC)),
		.busy(otb_busy),
		.done()
	);

	assign ot_fault = overvoltage_overtemp_input & ~otb_busy;

	// Fault inputs are only looked at outside the blanking window
	always_comb begin
		state_d = state_q;
		case (state_q)
			RCS_OFF: begin
				if (supply_above_release) begin
					state_d = RCS_CHARGING;
				end
			end
			RCS_CHARGING: begin
				if (on_rise) begin
					state_d = RCS_BLANKING;
				end
			end
			RCS_BLANKING: begin
				if (blk_done) begin
					if (!bulk_level_good) begin
						state_d = RCS_BROWNOUT_WAIT;
					end else if (overvoltage_overtemp_input) begin
						state_d = RCS_FAULT_SELF_SUPPLY;
					end else if (first_on_q && fb_below_skip_entry) begin
						state_d = RCS_BROWNOUT_WAIT;
					end else begin
						state_d = RCS_RUNNING;
					end
				end
			end
			RCS_RUNNING: begin
				if (ot_fault) begin
					state_d = RCS_LATCHED_OFF;
				end else if (!bulk_level_good) begin
					state_d = RCS_BROWNOUT_WAIT;
				end else if (overload_detect) begin
					state_d = RCS_RECOVERY_WAIT;
				end else if (fb_below_skip_entry) begin
					state_d = RCS_SKIP_IDLE;
				end
			end
			RCS_SKIP_IDLE: begin
				if (!supply_above_turn_off) begin
					state_d = RCS_OFF;
				end else if (fb_above_skip_exit) begin
					state_d = RCS_RUNNING;
				end
			end
			RCS_BROWNOUT_WAIT: begin
				if (bulk_level_good && !(first_on_q && fb_below_skip_entry)) begin
					state_d = RCS_CHARGING;
				end
			end
			RCS_FAULT_SELF_SUPPLY: begin
				if (!overvoltage_overtemp_input) begin
					state_d = RCS_CHARGING;
				end
			end
			RCS_RECOVERY_WAIT: begin
				if (rec_done) begin
					state_d = RCS_CHARGING;
				end
			end
			RCS_LATCHED_OFF: begin
				if (!supply_above_release) begin
					state_d = RCS_OFF;
				end
			end
			default: begin
				state_d = RCS_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= RCS_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs are registered from the next state so they track it with no lag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bulk_monitor_en <= 1'b0;
			feedback_en <= 1'b0;
			fault_sense_en <= 1'b0;
			fault_logic_en <= 1'b0;
			gate_drivers_en <= 1'b0;
			startup_source_en <= 1'b0;
			self_supply_mode <= 1'b0;
			output_a <= 1'b0;
			soft_start <= 1'b0;
		end else begin
			bulk_monitor_en <= 1'b0;
			feedback_en <= 1'b0;
			fault_sense_en <= 1'b0;
			fault_logic_en <= 1'b0;
			gate_drivers_en <= 1'b0;
			startup_source_en <= 1'b0;
			self_supply_mode <= 1'b0;
			output_a <= 1'b0;
			soft_start <= 1'b0;
			case (state_d)
				RCS_CHARGING: begin
					startup_source_en <= 1'b1;
					bulk_monitor_en <= ~first_on_q;
					feedback_en <= ~first_on_q;
					output_a <= ~first_on_q;
				end
				RCS_BLANKING: begin
					bulk_monitor_en <= 1'b1;
					feedback_en <= 1'b1;
					fault_sense_en <= 1'b1;
					fault_logic_en <= 1'b1;
					output_a <= 1'b1;
				end
				RCS_RUNNING: begin
					bulk_monitor_en <= 1'b1;
					feedback_en <= 1'b1;
					fault_sense_en <= 1'b1;
					fault_logic_en <= 1'b1;
					gate_drivers_en <= 1'b1;
					output_a <= 1'b1;
					soft_start <= (state_q == RCS_BLANKING);
				end
				RCS_SKIP_IDLE: begin
					feedback_en <= 1'b1;
				end
				RCS_BROWNOUT_WAIT: begin
					bulk_monitor_en <= 1'b1;
					feedback_en <= 1'b1;
					fault_logic_en <= 1'b1;
					self_supply_mode <= 1'b1;
					startup_source_en <= 1'b1;
					output_a <= 1'b1;
				end
				RCS_FAULT_SELF_SUPPLY: begin
					bulk_monitor_en <= 1'b1;
					feedback_en <= 1'b1;
					fault_sense_en <= 1'b1;
					fault_logic_en <= 1'b1;
					self_supply_mode <= 1'b1;
					startup_source_en <= 1'b1;
					output_a <= 1'b1;
				end
				RCS_RECOVERY_WAIT: begin
					feedback_en <= 1'b1;
					fault_logic_en <= 1'b1;
					self_supply_mode <= 1'b1;
					startup_source_en <= 1'b1;
				end
				RCS_LATCHED_OFF: begin
					feedback_en <= 1'b1;
					self_supply_mode <= 1'b1;
					startup_source_en <= 1'b1;
				end
				default: begin
					startup_source_en <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ot_blank_active <= 1'b0;
			seq_state <= RCS_OFF;
		end else begin
			ot_blank_active <= otb_busy | otb_start | blk_start;
			seq_state <= state_d;
		end
	end

endmodule : rcs_sequencer

// file: rcs_pkg.sv
// Constants shared by the resonant controller operating sequencer.
// Assumes a single 20 MHz clock and synchronous comparator flags.
package rcs_pkg;

	localparam int unsigned CLK_HZ = 20000000;
	// Supply blanking time in microseconds
	localparam int unsigned SUPPLY_BLANK_US = 10;
	localparam int unsigned SUPPLY_BLANK_CYC = (SUPPLY_BLANK_US * (CLK_HZ / 1000000) < 1) ? 1 :
		SUPPLY_BLANK_US * (CLK_HZ / 1000000);
	// Overtemperature blanking time in microseconds
	localparam int unsigned OT_BLANK_US = 5;
	localparam int unsigned OT_BLANK_CYC = (OT_BLANK_US * (CLK_HZ / 1000000) < 1) ? 1 :
		OT_BLANK_US * (CLK_HZ / 1000000);
	// Auto-recovery delay in milliseconds
	localparam int unsigned RECOVERY_DELAY_MS = 1000;
	localparam int unsigned RECOVERY_DELAY_CYC = RECOVERY_DELAY_MS * (CLK_HZ / 1000);

	localparam int CNT_W = 32;
	localparam int OTB_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

	typedef enum logic [3:0] {
		RCS_CHARGING,
		RCS_BLANKING,
		RCS_RUNNING,
		RCS_SKIP_IDLE,
		RCS_BROWNOUT_WAIT,
		RCS_FAULT_SELF_SUPPLY,
		RCS_RECOVERY_WAIT,
		RCS_LATCHED_OFF,
		RCS_OFF
	} rcs_state_e;

endpackage : rcs_pkg

// file: rcs_timer.sv
// One-shot down counter used for blanking and recovery periods.
// Assumes start is a single-cycle pulse on the shared clock.
`timescale 1ns/1ps
module rcs_timer #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [W-1:0] load,
	output logic busy,
	output logic done
);

	logic [W-1:0] cnt_q;

	// A restart while counting reloads the full period
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			done <= 1'b0;
		end else if (start) begin
			cnt_q <= load;
			done <= 1'b0;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			done <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
		end else begin
			done <= 1'b0;
		end
	end

	assign busy = (cnt_q != '0);

endmodule : rcs_timer

// file: rcs_sequencer_properties.sv
// Checker for the operating sequencer, bound to its ports.
// Assumes seq_state follows the enum order given in the package.
`timescale 1ns/1ps
module rcs_sequencer_properties
	import rcs_pkg::*;
#(
	parameter int unsigned RECOVERY_CYC = RECOVERY_DELAY_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic supply_above_release,
	input wire logic feedback_en,
	input wire logic bulk_monitor_en,
	input wire logic fault_sense_en,
	input wire logic fault_logic_en,
	input wire logic gate_drivers_en,
	input wire logic startup_source_en,
	input wire logic self_supply_mode,
	input wire logic output_a,
	input wire logic soft_start,
	input wire logic [3:0] seq_state
);
	// Dwell counter: cycles spent in the current state
	logic [31:0] dwell_q;
	always_ff @(posedge clk) begin
		if (sys_rst || $changed(seq_state)) dwell_q <= 32'h0;
		else dwell_q <= dwell_q + 32'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_charge_src_on: assert property (seq_state == 4'h0 |-> startup_source_en)
		else $error("startup source off while charging");
	a_blank_not_short: assert property (seq_state == 4'h1 && dwell_q < SUPPLY_BLANK_CYC - 2
		|=> seq_state == 4'h1) else $error("blanking ended early");
	a_blank_not_long: assert property (seq_state == 4'h1 |-> dwell_q <= SUPPLY_BLANK_CYC)
		else $error("blanking too long");
	a_drivers_only_run: assert property (gate_drivers_en |-> seq_state == 4'h2)
		else $error("drivers on outside running");
	a_soft_after_blank: assert property (soft_start |-> seq_state == 4'h2
		&& $past(seq_state) == 4'h1) else $error("soft start not from blanking");
	a_brownout_gating: assert property (seq_state == 4'h4 |-> output_a && self_supply_mode
		&& !gate_drivers_en && !fault_sense_en) else $error("brown-out gating");
	a_latch_gating: assert property (seq_state == 4'h7 |-> feedback_en && !gate_drivers_en
		&& !fault_sense_en && !bulk_monitor_en) else $error("latch gating");
	a_latch_holds: assert property (seq_state == 4'h7 && supply_above_release
		|=> seq_state == 4'h7) else $error("latch released early");
	a_recover_gating: assert property (seq_state == 4'h6 |-> feedback_en && fault_logic_en
		&& self_supply_mode && !gate_drivers_en) else $error("recovery gating");
	a_recover_delay: assert property (seq_state == 4'h6 && dwell_q < RECOVERY_CYC - 2
		|=> seq_state inside {4'h6, 4'h8}) else $error("recovery too fast");
	a_skip_gating: assert property (seq_state == 4'h3 |-> feedback_en && !gate_drivers_en
		&& !fault_sense_en && !startup_source_en) else $error("skip gating");
	c_running: cover property (soft_start);
	c_latched: cover property (seq_state == 4'h7);
	c_recovery: cover property (seq_state == 4'h6 ##1 seq_state == 4'h0);
endmodule : rcs_sequencer_properties
bind rcs_sequencer rcs_sequencer_properties #(.RECOVERY_CYC(RECOVERY_CYC)) chk (
	.clk(clk),
	.sys_rst(sys_rst),
	.supply_above_release(supply_above_release),
	.feedback_en(feedback_en),
	.bulk_monitor_en(bulk_monitor_en),
	.fault_sense_en(fault_sense_en),
	.fault_logic_en(fault_logic_en),
	.gate_drivers_en(gate_drivers_en),
	.startup_source_en(startup_source_en),
	.self_supply_mode(self_supply_mode),
	.output_a(output_a),
	.soft_start(soft_start),
	.seq_state(seq_state)
);

// file: rcs_supply_model.sv
// Behavioural supply capacitor and its comparators.
// Assumes the startup source charges and the aux winding holds while drivers run.
`timescale 1ns/1ps
module rcs_supply_model (
	input wire logic clk,
	input wire logic unplug,
	input wire logic startup_source_en,
	input wire logic self_supply_mode,
	input wire logic gate_drivers_en,
	output logic supply_above_turn_on,
	output logic supply_above_turn_off,
	output logic supply_above_release
);
	logic [7:0] level_q = 8'h00;
	// The capacitor drains slowly, so a blanking period costs only a few steps
	logic [5:0] slow_q = 6'h00;
	always_ff @(posedge clk) begin
		slow_q <= slow_q + 6'h01;
		// Self-supply only tops up to mid level, so turn-on must be re-crossed later
		if (!unplug && level_q < 8'h28 && ((startup_source_en && !self_supply_mode)
			|| level_q < 8'h08 || (self_supply_mode && level_q < 8'h18)))
			level_q <= level_q + 8'h01;
		else if ((unplug || !gate_drivers_en) && slow_q == 6'h00 && level_q != 8'h00)
			level_q <= level_q - 8'h01;
	end
	assign supply_above_turn_on = level_q >= 8'h20;
	assign supply_above_turn_off = level_q >= 8'h10;
	assign supply_above_release = level_q >= 8'h08;
endmodule : rcs_supply_model

// file: rcs_sequencer_bench.sv
// Self-checking bench for the operating sequencer with a supply model.
// Assumes a 50 ns clock and a shortened recovery delay.
`timescale 1ns/1ps
module rcs_sequencer_bench;
	import rcs_pkg::*;
	localparam int unsigned REC = 50;
	logic clk = 0, sys_rst = 1, unplug = 0, bulk_ok = 0, fb_low = 0, fb_high = 0;
	logic ovot = 0, ovl = 0, on_l, off_l, rel_l, bm, fe, fs, fl, ge, se, ss, oa, st, ob;
	logic [3:0] st_q;
	int error_cnt = 0, checked = 0;
	rcs_sequencer #(.RECOVERY_CYC(REC)) uut (.clk(clk), .sys_rst(sys_rst),
		.supply_above_turn_on(on_l), .supply_above_turn_off(off_l),
		.supply_above_release(rel_l), .bulk_level_good(bulk_ok),
		.fb_below_skip_entry(fb_low), .fb_above_skip_exit(fb_high),
		.overvoltage_overtemp_input(ovot), .overload_detect(ovl), .bulk_monitor_en(bm),
		.feedback_en(fe), .fault_sense_en(fs), .fault_logic_en(fl), .gate_drivers_en(ge),
		.startup_source_en(se), .self_supply_mode(ss), .output_a(oa), .soft_start(st),
		.ot_blank_active(ob), .seq_state(st_q));
	rcs_supply_model sup (.clk(clk), .unplug(unplug), .startup_source_en(se),
		.self_supply_mode(ss), .gate_drivers_en(ge), .supply_above_turn_on(on_l),
		.supply_above_turn_off(off_l), .supply_above_release(rel_l));
	initial forever #25 clk = ~clk;
	task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	// Bounded wait for a state; a hang ends the run
	task automatic reach(input rcs_state_e s);
		int n;
		// Looks just after each edge, so one-cycle outputs of the entry edge still stand
		for (n = 0; n < 3000 && st_q !== 4'(s); n++) begin
			@(posedge clk);
			#1;
		end
		chk(s.name(), st_q, 4'(s));
		if (st_q !== 4'(s)) conclude();
	endtask : reach
	task automatic t_start;
		reach(RCS_BLANKING);
		chk("first_bias", {bm, fe, fs, oa}, 4'hf);
		reach(RCS_BROWNOUT_WAIT);
		chk("no_drive", {ge, ss}, 4'h1);
		@(posedge clk) bulk_ok <= 1;
		reach(RCS_CHARGING);
		reach(RCS_RUNNING);
		chk("started", {ge, st}, 4'h3);
		$display("start done");
	endtask : t_start
	task automatic t_bulk_loss;
		@(posedge clk) bulk_ok <= 0;
		reach(RCS_BROWNOUT_WAIT);
		chk("bo_out", {ge, fs, oa, ss}, 4'h3);
		@(posedge clk) bulk_ok <= 1;
		reach(RCS_BLANKING);
		chk("bo_rebias", fs, 4'h1);
		reach(RCS_RUNNING);
		$display("bulk loss done");
	endtask : t_bulk_loss
	task automatic t_latch;
		@(posedge clk) ovot <= 1;
		reach(RCS_LATCHED_OFF);
		chk("latch", {fe, ge, fs}, 4'h4);
		@(posedge clk) ovot <= 0;
		repeat (100) @(posedge clk);
		chk("latch_hold", st_q, 4'(RCS_LATCHED_OFF));
		@(posedge clk) unplug <= 1;
		reach(RCS_OFF);
		@(posedge clk) unplug <= 0;
		reach(RCS_RUNNING);
		$display("latch done");
	endtask : t_latch
	task automatic t_overload;
		@(posedge clk) ovl <= 1;
		reach(RCS_RECOVERY_WAIT);
		chk("ovl_gate", {fe, fl, ge}, 4'h6);
		@(posedge clk) ovl <= 0;
		reach(RCS_CHARGING);
		chk("rec_src", se, 4'h1);
		reach(RCS_BLANKING);
		chk("rec_blank", ob, 4'h1);
		reach(RCS_RUNNING);
		$display("overload done");
	endtask : t_overload
	task automatic t_skip;
		@(posedge clk) fb_low <= 1;
		reach(RCS_SKIP_IDLE);
		chk("skip_off", {fe, ge, se, bm}, 4'h8);
		@(posedge clk) begin
			fb_low <= 0;
			fb_high <= 1;
		end
		reach(RCS_RUNNING);
		chk("burst", {ge, se, ob}, 4'h5);
		@(posedge clk) begin
			fb_high <= 0;
			fb_low <= 1;
		end
		reach(RCS_SKIP_IDLE);
		reach(RCS_OFF);
		$display("skip done");
	endtask : t_skip
	// Mid-run reset: first turn-on under light load, then a fault at blanking end
	task automatic t_first_on;
		reach(RCS_SKIP_IDLE);
		@(posedge clk) sys_rst <= 1;
		repeat (20) @(posedge clk);
		sys_rst <= 0;
		reach(RCS_BLANKING);
		reach(RCS_BROWNOUT_WAIT);
		repeat (50) @(posedge clk);
		chk("fb_hold", st_q, 4'(RCS_BROWNOUT_WAIT));
		chk("fb_no_drive", ge, 4'h0);
		@(posedge clk) fb_low <= 0;
		reach(RCS_BLANKING);
		@(posedge clk) ovot <= 1;
		reach(RCS_FAULT_SELF_SUPPLY);
		chk("ov_hold", {ge, ss, fs}, 4'h3);
		@(posedge clk) ovot <= 0;
		reach(RCS_CHARGING);
		chk("ov_retry", se, 4'h1);
		reach(RCS_RUNNING);
		$display("first turn-on done");
	endtask : t_first_on
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 0;
		t_start();
		t_bulk_loss();
		t_latch();
		t_overload();
		t_skip();
		t_first_on();
		conclude();
	end
endmodule : rcs_sequencer_bench
